/* hdl/rsp_device.sv */
`timescale 1ns/1ps
// Summary of operation
// - Host is master, at most 4 Mbps
// - Standby or power down: at most 1 Mbps
// - Falling chip select starts each command
// - Status byte shifts out with command
// - Command then data, low byte first
// - Register read returns up to five bytes
// - Register write only while idle
// - Payload read returns, then drops, oldest
// - Transmit write stores one payload
// - Flush commands empty transmit, receive queues
// - Resend last payload until flush
// - Feature key unlocks or locks extras
// - Width read returns head payload length
// - Two pending acknowledge payloads, in order
// - No-acknowledge transmit payload write
// - Radio enable forced on or off
// - Soft reset held or released
// - Short register write keeps upper bytes
// - Host sets dynamic length enables
// - Static length equals written byte count
// - Write one clears flag and request
module rsp_device (
  input wire logic clock,
  input wire logic reset,
  rsp_link_if.device link,
  input wire logic idleMode,
  input wire logic txBusy,
  input wire logic txSent,
  input wire logic retryLimit,
  input wire logic rxWrEn,
  input wire logic [5:0] rxWrIdx,
  input wire logic [7:0] rxWrByte,
  input wire logic rxPush,
  input wire logic [6:0] rxPushLen,
  input wire logic ackTake,
  input wire logic [1:0] rdSlot,
  input wire logic [5:0] rdIdx,
  output logic [7:0] rdByte_q,
  output logic txPending_q,
  output logic [6:0] txLen_q,
  output logic txNoAck_q,
  output logic resend_q,
  output logic ackReady_q,
  output logic [1:0] ackSlot_q,
  output logic [2:0] ackPipe_q,
  output logic [6:0] ackLen_q,
  output logic radioEnable_q,
  output logic softReset_q,
  output logic featuresOpen_q,
  output logic irqLow_q
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] regs_q [rsp_pkg::REG_COUNT][rsp_pkg::REG_BYTES];
  logic [7:0] mem_q [4][rsp_pkg::PAY_BYTES];
  logic [2:0] sckS_q, csS_q;
  logic [1:0] mosiS_q;
  logic active_q;
  logic [2:0] bitCnt_q;
  logic [6:0] byteCnt_q;
  logic [6:0] rxShift_q;
  logic [7:0] cmd_q, out_q, nextOut_q;
  logic isPayWr_q, noAck_q;
  logic [1:0] paySlot_q;
  logic [6:0] payLen_q;
  logic rxValid_q;
  logic [6:0] rxLen_q;
  logic [2:0] flags_q;
  logic [1:0] ackValid_q;
  logic ackHead_q;
  logic [2:0] ackPipeA_q, ackPipeB_q;
  logic [6:0] ackLenA_q, ackLenB_q;
  logic [2:0] ackPipeCmd_q;

  logic sckRise, sckFall, csFall, csRise, byteDone;
  logic [7:0] fullByte, cmdNow, status, replyByte;
  logic [6:0] dataIdx;
  logic [4:0] regIdx;
  logic [2:0] flagClr, flagSet;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage 1 and 2 feed logic
  always_ff @(posedge clock) begin
    sckS_q <= {sckS_q[1:0], link.sck};
    csS_q <= {csS_q[1:0], link.chipSelectLow};
    mosiS_q <= {mosiS_q[0], link.mosi};
  end

  assign sckRise = sckS_q[1] & ~sckS_q[2];
  assign sckFall = ~sckS_q[1] & sckS_q[2];
  assign csFall = ~csS_q[1] & csS_q[2];
  assign csRise = csS_q[1] & ~csS_q[2];
  assign byteDone = active_q & sckRise & (bitCnt_q == 3'd7);
  assign fullByte = {rxShift_q, mosiS_q[1]};
  assign cmdNow = (byteCnt_q == 7'd0) ? fullByte : cmd_q;
  assign dataIdx = byteCnt_q - 7'd1;
  assign regIdx = cmd_q[4:0];
  assign status = {1'b0, flags_q, rxValid_q ? 3'h0 : rsp_pkg::RX_EMPTY_CODE,
                   txPending_q};

  // Reply for the byte that follows; index counts from data byte 0
  always_comb begin
    replyByte = 8'h00;
    if (cmdNow[7:5] == rsp_pkg::CMD_REG_READ) begin
      if (byteCnt_q < rsp_pkg::REG_BYTES_W) begin
        if (cmdNow[4:0] == rsp_pkg::STATUS_INDEX) replyByte = status;
        else replyByte = regs_q[cmdNow[4:0]][byteCnt_q[2:0]];
      end
    end else if (cmdNow == rsp_pkg::CMD_RX_READ) begin
      if (byteCnt_q < rsp_pkg::PAY_BYTES_W)
        replyByte = mem_q[rsp_pkg::SLOT_RX][byteCnt_q[5:0]];
    end else if (cmdNow == rsp_pkg::CMD_RX_WIDTH && featuresOpen_q) begin
      if (byteCnt_q == 7'd0) replyByte = {1'b0, rxLen_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking: bit and byte counters, command capture
  always_ff @(posedge clock) begin
    if (reset) begin
      active_q <= 1'b0;
      bitCnt_q <= 3'd0;
      byteCnt_q <= 7'd0;
      rxShift_q <= 7'd0;
      cmd_q <= 8'h00;
      nextOut_q <= 8'h00;
    end else if (csFall) begin
      active_q <= 1'b1;
      bitCnt_q <= 3'd0;
      byteCnt_q <= 7'd0;
    end else if (csRise) begin
      active_q <= 1'b0;
    end else if (active_q && sckRise) begin
      rxShift_q <= fullByte[6:0];
      bitCnt_q <= bitCnt_q + 3'd1;
      if (byteDone) begin
        nextOut_q <= replyByte;
        if (byteCnt_q == 7'd0) cmd_q <= fullByte;
        // saturate, extra bytes fall out of range
        if (byteCnt_q != rsp_pkg::BYTE_CNT_MAX)
          byteCnt_q <= byteCnt_q + 7'd1;
      end
    end
  end

  // Data-out shifter; loads the next reply after each full byte
  always_ff @(posedge clock) begin
    if (reset) begin
      out_q <= 8'h00;
      link.misoOeN <= 1'b1;
    end else if (csFall) begin
      out_q <= status;
      link.misoOeN <= 1'b0;
    end else if (csRise) begin
      link.misoOeN <= 1'b1;
    end else if (active_q && sckFall) begin
      if (bitCnt_q == 3'd0 && byteCnt_q != 7'd0) out_q <= nextOut_q;
      else out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign link.misoOut = out_q[7];

  ////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int r = 0; r < rsp_pkg::REG_COUNT; r++)
        for (int b = 0; b < rsp_pkg::REG_BYTES; b++)
          regs_q[r][b] <= rsp_pkg::REG_RESET;
    end else if (byteDone && byteCnt_q != 7'd0 && idleMode &&
                 cmd_q[7:5] == rsp_pkg::CMD_REG_WRITE &&
                 regIdx != rsp_pkg::STATUS_INDEX) begin
      if (dataIdx < rsp_pkg::REG_BYTES_W)
        regs_q[regIdx][dataIdx[2:0]] <= fullByte;
    end
  end

  // Status flags: hardware set wins over a write-one clear
  always_comb begin
    flagClr = 3'h0;
    if (byteDone && byteCnt_q == 7'd1 && idleMode &&
        cmd_q[7:5] == rsp_pkg::CMD_REG_WRITE &&
        regIdx == rsp_pkg::STATUS_INDEX)
      flagClr = fullByte[6:4];
    flagSet = {rxPush, txSent, retryLimit};
  end

  always_ff @(posedge clock) begin
    if (reset) flags_q <= 3'h0;
    else flags_q <= (flags_q & ~flagClr) | flagSet;
  end

  // Interrupt request follows unmasked flags
  always_ff @(posedge clock) begin
    if (reset) irqLow_q <= 1'b1;
    else irqLow_q <= ~|(flags_q & ~regs_q[rsp_pkg::CONFIG_INDEX][0][6:4]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Payload memory: slot 0 transmit, 1-2 acknowledge, 3 receive
  always_ff @(posedge clock) begin
    if (byteDone && isPayWr_q && byteCnt_q != 7'd0 &&
        dataIdx < rsp_pkg::PAY_BYTES_W)
      mem_q[paySlot_q][dataIdx[5:0]] <= fullByte;
    if (rxWrEn) mem_q[rsp_pkg::SLOT_RX][rxWrIdx] <= rxWrByte;
  end

  // Per-frame payload write setup, decided on the command byte
  always_ff @(posedge clock) begin
    if (reset || csFall) begin
      isPayWr_q <= 1'b0;
      noAck_q <= 1'b0;
      paySlot_q <= rsp_pkg::SLOT_TX;
      payLen_q <= 7'd0;
      ackPipeCmd_q <= 3'd0;
    end else if (byteDone && byteCnt_q == 7'd0) begin
      if (fullByte == rsp_pkg::CMD_TX_WRITE) begin
        isPayWr_q <= 1'b1;
      end else if (fullByte == rsp_pkg::CMD_TX_NO_ACK && featuresOpen_q) begin
        isPayWr_q <= 1'b1;
        noAck_q <= 1'b1;
      end else if (fullByte[7:3] == rsp_pkg::CMD_ACK_WRITE &&
                   featuresOpen_q && fullByte[2:0] <= rsp_pkg::ACK_PIPE_MAX &&
                   ackValid_q != 2'b11) begin
        isPayWr_q <= 1'b1;
        paySlot_q <= ackValid_q[0] ? rsp_pkg::SLOT_ACK_B
                                   : rsp_pkg::SLOT_ACK_A;
        ackPipeCmd_q <= fullByte[2:0];
      end
    end else if (byteDone && isPayWr_q && dataIdx < rsp_pkg::PAY_BYTES_W) begin
      payLen_q <= byteCnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit queue and resend
  always_ff @(posedge clock) begin
    if (reset) begin
      txPending_q <= 1'b0;
      txLen_q <= 7'd0;
      txNoAck_q <= 1'b0;
      resend_q <= 1'b0;
    end else if (byteDone && byteCnt_q == 7'd0 &&
                 fullByte == rsp_pkg::CMD_FLUSH_TX) begin
      txPending_q <= 1'b0;
      resend_q <= 1'b0;
    end else if (byteDone && byteCnt_q == 7'd0 &&
                 fullByte == rsp_pkg::CMD_RESEND && !txBusy) begin
      resend_q <= 1'b1;
    end else if (csRise && isPayWr_q && paySlot_q == rsp_pkg::SLOT_TX &&
                 payLen_q != 7'd0) begin
      txPending_q <= 1'b1;
      txLen_q <= payLen_q;
      txNoAck_q <= noAck_q;
    end else if (txSent && !resend_q) begin
      txPending_q <= 1'b0;
    end
  end

  // Receive queue
  always_ff @(posedge clock) begin
    if (reset) begin
      rxValid_q <= 1'b0;
      rxLen_q <= 7'd0;
    end else if (rxPush) begin
      rxValid_q <= 1'b1;
      rxLen_q <= rxPushLen;
    end else if (byteDone && byteCnt_q == 7'd0 &&
                 fullByte == rsp_pkg::CMD_FLUSH_RX) begin
      rxValid_q <= 1'b0;
    end else if (csRise && cmd_q == rsp_pkg::CMD_RX_READ &&
                 byteCnt_q > 7'd1) begin
      rxValid_q <= 1'b0;
    end
  end

  // Acknowledge payload pair, served oldest first
  always_ff @(posedge clock) begin
    if (reset) begin
      ackValid_q <= 2'b00;
      ackHead_q <= 1'b0;
      ackPipeA_q <= 3'd0;
      ackPipeB_q <= 3'd0;
      ackLenA_q <= 7'd0;
      ackLenB_q <= 7'd0;
    end else if (csRise && isPayWr_q && paySlot_q != rsp_pkg::SLOT_TX &&
                 payLen_q != 7'd0) begin
      // queue entry, first in first out
      if (paySlot_q == rsp_pkg::SLOT_ACK_A) begin
        ackValid_q[0] <= 1'b1;
        ackPipeA_q <= ackPipeCmd_q;
        ackLenA_q <= payLen_q;
        if (!ackValid_q[1]) ackHead_q <= 1'b0;
      end else begin
        ackValid_q[1] <= 1'b1;
        ackPipeB_q <= ackPipeCmd_q;
        ackLenB_q <= payLen_q;
        if (!ackValid_q[0]) ackHead_q <= 1'b1;
      end
    end else if (ackTake && ackValid_q[ackHead_q]) begin
      ackValid_q[ackHead_q] <= 1'b0;
      ackHead_q <= ~ackHead_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-byte keyed commands
  always_ff @(posedge clock) begin
    if (reset) begin
      featuresOpen_q <= 1'b0;
      radioEnable_q <= 1'b0;
      softReset_q <= 1'b0;
    end else if (byteDone && byteCnt_q == 7'd1) begin
      if (cmd_q == rsp_pkg::CMD_FEATURE && idleMode) begin
        if (fullByte == rsp_pkg::KEY_UNLOCK) featuresOpen_q <= 1'b1;
        if (fullByte == rsp_pkg::KEY_LOCK) featuresOpen_q <= 1'b0;
      end
      if (fullByte == rsp_pkg::KEY_RADIO) begin
        if (cmd_q == rsp_pkg::CMD_RADIO_ON) radioEnable_q <= 1'b1;
        if (cmd_q == rsp_pkg::CMD_RADIO_OFF) radioEnable_q <= 1'b0;
      end
      if (cmd_q == rsp_pkg::CMD_SOFT_RESET) begin
        if (fullByte == rsp_pkg::KEY_RST_HOLD) softReset_q <= 1'b1;
        if (fullByte == rsp_pkg::KEY_RST_RELEASE) softReset_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // User-side readout, one cycle behind the request
  always_ff @(posedge clock) begin
    if (reset) begin
      rdByte_q <= 8'h00;
      ackReady_q <= 1'b0;
      ackSlot_q <= rsp_pkg::SLOT_ACK_A;
      ackPipe_q <= 3'd0;
      ackLen_q <= 7'd0;
    end else begin
      rdByte_q <= mem_q[rdSlot][rdIdx];
      ackReady_q <= ackValid_q[ackHead_q];
      ackSlot_q <= ackHead_q ? rsp_pkg::SLOT_ACK_B : rsp_pkg::SLOT_ACK_A;
      ackPipe_q <= ackHead_q ? ackPipeB_q : ackPipeA_q;
      ackLen_q <= ackHead_q ? ackLenB_q : ackLenA_q;
    end
  end

endmodule

/* hdl/rsp_pkg.sv */
package rsp_pkg;

  // Command words
  localparam logic [2:0] CMD_REG_READ = 3'h0;
  localparam logic [2:0] CMD_REG_WRITE = 3'h1;
  localparam logic [7:0] CMD_RX_READ = 8'h61;
  localparam logic [7:0] CMD_RX_WIDTH = 8'h60;
  localparam logic [7:0] CMD_TX_WRITE = 8'ha0;
  localparam logic [7:0] CMD_TX_NO_ACK = 8'hb0;
  localparam logic [4:0] CMD_ACK_WRITE = 5'h15;
  localparam logic [7:0] CMD_FLUSH_TX = 8'he1;
  localparam logic [7:0] CMD_FLUSH_RX = 8'he2;
  localparam logic [7:0] CMD_RESEND = 8'he3;
  localparam logic [7:0] CMD_FEATURE = 8'h50;
  localparam logic [7:0] CMD_RADIO_ON = 8'hfd;
  localparam logic [7:0] CMD_RADIO_OFF = 8'hfc;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h53;

  // Data keys that follow single-byte commands
  localparam logic [7:0] KEY_UNLOCK = 8'h73;
  localparam logic [7:0] KEY_LOCK = 8'h8c;
  localparam logic [7:0] KEY_RADIO = 8'h00;
  localparam logic [7:0] KEY_RST_HOLD = 8'h5a;
  localparam logic [7:0] KEY_RST_RELEASE = 8'ha5;

  // Register file and queue geometry
  localparam int REG_COUNT = 32;
  localparam int REG_BYTES = 5;
  localparam logic [6:0] REG_BYTES_W = 7'd5;
  localparam int PAY_BYTES = 64;
  localparam logic [6:0] PAY_BYTES_W = 7'd64;
  localparam logic [2:0] ACK_PIPE_MAX = 3'd5;
  localparam logic [4:0] STATUS_INDEX = 5'd7;
  localparam logic [4:0] CONFIG_INDEX = 5'd0;
  localparam logic [1:0] SLOT_TX = 2'd0;
  localparam logic [1:0] SLOT_ACK_A = 2'd1;
  localparam logic [1:0] SLOT_ACK_B = 2'd2;
  localparam logic [1:0] SLOT_RX = 2'd3;
  localparam logic [6:0] BYTE_CNT_MAX = 7'd127;
  localparam logic [2:0] RX_EMPTY_CODE = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Host register offsets and fields
  localparam logic [1:0] HOST_CTRL = 2'h0;
  localparam logic [1:0] HOST_DATA = 2'h1;
  localparam logic [1:0] HOST_STATUS = 2'h2;
  localparam int CTRL_SELECT = 0;
  localparam int CTRL_SLOW = 1;

  // Serial clock timing
  localparam int CLOCK_NS = 50;
  localparam int FAST_HALF_NS = 200;
  localparam int SLOW_HALF_NS = 500;
  localparam logic [4:0] FAST_HALF_CYC = 5'(FAST_HALF_NS / CLOCK_NS);
  localparam logic [4:0] SLOW_HALF_CYC = 5'(SLOW_HALF_NS / CLOCK_NS);

endpackage

/* hdl/rsp_link_if.sv */
`timescale 1ns/1ps
interface rsp_link_if;
  logic sck;
  logic chipSelectLow;
  logic mosi;
  logic misoOut;
  logic misoOeN;
  wire misoWire;

  // Device drives the data-out line only while selected; when released the
  // line shows the inverse, so a sample taken too early shows up as an error
  assign misoWire = misoOeN ? ~misoOut : misoOut;

  modport device (
    input sck,
    input chipSelectLow,
    input mosi,
    output misoOut,
    output misoOeN
  );

  modport host (
    output sck,
    output chipSelectLow,
    output mosi,
    input misoWire
  );
endinterface

/* hdl/rsp_host.sv */
`timescale 1ns/1ps
module rsp_host (
  input wire logic clock,
  input wire logic reset,
  rsp_link_if.host link,
  input wire logic [1:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData
);

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} rsp_host_state_t;

  rsp_host_state_t state_q;
  logic [1:0] misoS_q;
  logic select_q, slow_q;
  logic [4:0] cnt_q;
  logic [3:0] bitsLeft_q;
  logic [7:0] txShift_q, rxByte_q;
  logic [4:0] half;
  logic startByte;

  ////////////////////////////////////////////////////////////////////////
  // Returned data pin passes two flops
  always_ff @(posedge clock) begin
    misoS_q <= {misoS_q[0], link.misoWire};
  end

  // fast rate stays under the ceiling
  assign half = slow_q ? rsp_pkg::SLOW_HALF_CYC : rsp_pkg::FAST_HALF_CYC;
  assign startByte = writeStrobe && address == rsp_pkg::HOST_DATA &&
                     select_q && state_q == H_IDLE;

  // Control register; select changes only between bytes
  always_ff @(posedge clock) begin
    if (reset) begin
      select_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (writeStrobe && address == rsp_pkg::HOST_CTRL &&
                 state_q == H_IDLE) begin
      select_q <= writeData[rsp_pkg::CTRL_SELECT];
      slow_q <= writeData[rsp_pkg::CTRL_SLOW];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) link.chipSelectLow <= 1'b1;
    else link.chipSelectLow <= ~select_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte engine: clock idles low, data changes on the falling edge
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= H_IDLE;
      cnt_q <= 5'd0;
      bitsLeft_q <= 4'd0;
      txShift_q <= 8'h00;
      rxByte_q <= 8'h00;
      link.sck <= 1'b0;
      link.mosi <= 1'b0;
    end else begin
      unique case (state_q)
        H_IDLE: begin
          if (startByte) begin
            txShift_q <= {writeData[6:0], 1'b0};
            link.mosi <= writeData[7];
            bitsLeft_q <= 4'd8;
            cnt_q <= half - 5'd1;
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (cnt_q == 5'd0) begin
            link.sck <= 1'b1;
            cnt_q <= half - 5'd1;
            state_q <= H_HIGH;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        H_HIGH: begin
          if (cnt_q == 5'd0) begin
            // Sampled late in the high phase, well after device update
            rxByte_q <= {rxByte_q[6:0], misoS_q[1]};
            link.sck <= 1'b0;
            bitsLeft_q <= bitsLeft_q - 4'd1;
            cnt_q <= half - 5'd1;
            if (bitsLeft_q == 4'd1) begin
              state_q <= H_IDLE;
            end else begin
              link.mosi <= txShift_q[7];
              txShift_q <= {txShift_q[6:0], 1'b0};
              state_q <= H_LOW;
            end
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      unique case (address)
        rsp_pkg::HOST_CTRL: readData <= {6'h00, slow_q, select_q};
        rsp_pkg::HOST_DATA: readData <= rxByte_q;
        rsp_pkg::HOST_STATUS: readData <= {7'h00, state_q != H_IDLE};
        default: readData <= 8'h00;
      endcase
    end else begin
      readData <= 8'h00;
    end
  end

endmodule

/* tb/rsp_link_properties.sv */
`timescale 1ns/1ps
module rsp_link_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic sck,
  input wire logic chipSelectLow,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOeN
);
  default clocking linkClk @(posedge clock);
  endclocking
  default disable iff (reset);

  logic [9:0] rises_q;

  // Rises in this frame; cleared while deselected
  always_ff @(posedge clock) begin
    if (reset || chipSelectLow) begin
      rises_q <= '0;
    end else if ($rose(sck)) begin
      rises_q <= rises_q + 10'd1;
    end
  end

  ////////////////////////////////////////
  idle_sck_low_a:
    assert property (chipSelectLow |-> !sck)
    else $error("serial clock moved while deselected");
  select_setup_a:
    assert property ($fell(chipSelectLow) |-> (!sck) [*4])
    else $error("serial clock rose too soon after select");
  deselect_gap_a:
    assert property ($rose(chipSelectLow) |=> chipSelectLow)
    else $error("select high for a single cycle");
  sck_high_time_a:
    assert property ($rose(sck) |=> sck [*3])
    else $error("serial clock high phase too short");
  sck_low_time_a:
    assert property ($fell(sck) |=> (!sck) [*3])
    else $error("serial clock low phase too short");
  mosi_steady_a:
    assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while clock high");
  miso_steady_a:
    assert property (sck && $past(sck) |-> $stable(misoOut))
    else $error("device data moved while clock high");
  status_lead_a:
    assert property ($rose(sck) && rises_q == 10'd0 |-> !misoOeN && !misoOut)
    else $error("status top bit not driven first");
  drive_on_a:
    assert property ($fell(chipSelectLow) |-> ##[1:6] !misoOeN)
    else $error("device did not drive after select");
  drive_off_a:
    assert property ($rose(chipSelectLow) |-> ##[0:6] misoOeN)
    else $error("device kept driving after deselect");
  whole_bytes_a:
    assert property ($rose(chipSelectLow) |-> rises_q[2:0] == 3'd0)
    else $error("frame ended inside a byte");

  // Short, table and long frames seen
  cover property ($rose(chipSelectLow) && rises_q == 10'd8);
  cover property ($rose(chipSelectLow) && rises_q == 10'd16);
  cover property ($rose(chipSelectLow) && rises_q == 10'd48);
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clock;
  logic reset = 1'b1;
  logic [1:0] address = '0;
  logic [7:0] writeData = '0;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [7:0] readData;
  logic idleMode = 1'b1;
  logic rxWrEn = 1'b0;
  logic rxPush = 1'b0;
  logic [5:0] rxWrIdx = '0;
  logic [5:0] rdIdx = '0;
  logic [7:0] rxWrByte = '0;
  logic [6:0] rxPushLen = '0;
  logic [1:0] rdSlot = '0;
  logic [7:0] rdByte_q;
  logic [6:0] txLen_q;
  logic txPending_q, radioEnable_q, softReset_q, featuresOpen_q, irqLow_q;
  logic [7:0] tx[8] = '{default: 8'h00};
  logic [7:0] rx[8] = '{default: 8'h00};
  logic txBusy = 1'b0;
  logic txSent = 1'b0;
  logic retryLimit = 1'b0;
  logic ackTake = 1'b0;
  logic txNoAck_q, resend_q, ackReady_q;
  logic [1:0] ackSlot_q;
  logic [2:0] ackPipe_q;
  logic [6:0] ackLen_q;
  logic [7:0] ctrlOn = 8'h01;
  int badCount = 0;
  int checksDone = 0;
  // Command, key, then expected {radio, held reset, extras open}
  logic [18:0] rows[9] = '{{16'h508c, 3'b000}, {16'hfd00, 3'b100},
    {16'hfc00, 3'b000}, {16'hfd01, 3'b000}, {16'h535a, 3'b010},
    {16'h53a5, 3'b000}, {16'h5073, 3'b001}, {16'hff00, 3'b001},
    {16'h5073, 3'b001}};

  rsp_link_if link();
  rsp_host rsp_host_inst (.clock, .reset, .link(link.host), .address,
    .writeData, .writeStrobe, .readStrobe, .readData);
  rsp_device rsp_device_inst (.clock, .reset, .link(link.device), .idleMode,
    .txBusy, .txSent, .retryLimit, .rxWrEn, .rxWrIdx,
    .rxWrByte, .rxPush, .rxPushLen, .ackTake, .rdSlot, .rdIdx,
    .rdByte_q, .txPending_q, .txLen_q, .txNoAck_q, .resend_q,
    .ackReady_q, .ackSlot_q, .ackPipe_q, .ackLen_q, .radioEnable_q,
    .softReset_q, .featuresOpen_q, .irqLow_q);
  rsp_link_properties rsp_link_properties_inst (.clock, .reset,
    .sck(link.sck), .chipSelectLow(link.chipSelectLow), .mosi(link.mosi),
    .misoOut(link.misoOut), .misoOeN(link.misoOeN));

  ////////////////////////////////////////
  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Single-cycle bus strokes, changed just after the edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask

  // One selected frame; busy polled with a bound so a hang is cut short
  task automatic frame(input int n);
    logic [7:0] s;
    int k;
    wr(rsp_pkg::HOST_CTRL, ctrlOn);
    for (int i = 0; i < n; i++) begin
      wr(rsp_pkg::HOST_DATA, tx[i]);
      s = 8'h01;
      k = 0;
      while (s[0] && k < 300) begin
        rd(rsp_pkg::HOST_STATUS, s);
        k++;
      end
      // Stuck busy counts as a mismatch
      if (s[0]) badCount++;
      rd(rsp_pkg::HOST_DATA, rx[i]);
    end
    wr(rsp_pkg::HOST_CTRL, 8'h00);
    repeat (6) @(posedge clock);
  endtask

  ////////////////////////////////////////
  // Watchdog sized well above the expected run
  initial begin
    repeat (80000) @(posedge clock);
    badCount++;
    endOfTest();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    // Key commands, one row per frame
    foreach (rows[r]) begin
      {tx[0], tx[1]} = rows[r][18:3];
      frame(2);
      chk(8'({radioEnable_q, softReset_q, featuresOpen_q}), 8'(rows[r][2:0]));
    end
    // Two received bytes offered to the queue
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      rxWrEn <= 1'b1;
      rxWrIdx <= 6'(i);
      rxWrByte <= 8'(8'hc0 + i);
    end
    @(posedge clock);
    rxWrEn <= 1'b0;
    rxPush <= 1'b1;
    rxPushLen <= 7'd2;
    @(posedge clock);
    rxPush <= 1'b0;
    {tx[0], tx[1]} = 16'h60ff;
    frame(2);
    chk(rx[0], 8'h40);
    chk(rx[1], 8'h02);
    tx[0] = 8'h61;
    frame(3);
    chk(rx[1], 8'hc0);
    chk(rx[2], 8'hc1);
    chk(8'(irqLow_q), 8'h00);
    {tx[0], tx[1]} = 16'h2740;
    frame(2);
    chk(rx[0], 8'h4e);
    chk(8'(irqLow_q), 8'h01);
    // Full register write, then read back
    for (int i = 1; i < 6; i++)
      tx[i] = 8'(8'h11 * i);
    tx[0] = 8'h2a;
    frame(6);
    tx[0] = 8'h0a;
    frame(6);
    chk(rx[0], 8'h0e);
    for (int i = 1; i < 6; i++)
      chk(rx[i], 8'(8'h11 * i));
    // Slow serial rate; short write while the device idles, refused write and read back once it does not
    ctrlOn = 8'h03;
    {tx[0], tx[1]} = 16'h2a99;
    frame(2);
    idleMode <= 1'b0;
    {tx[0], tx[1]} = 16'h2a77;
    frame(2);
    tx[0] = 8'h0a;
    frame(6);
    chk(rx[1], 8'h99);
    chk(rx[2], 8'h22);
    // Payload of three bytes, then flushed
    ctrlOn = 8'h01;
    tx[0] = 8'ha0;
    frame(4);
    chk(8'(txLen_q), 8'h03);
    chk(8'(txPending_q), 8'h01);
    rdSlot <= rsp_pkg::SLOT_TX;
    rdIdx <= 6'd2;
    repeat (2) @(posedge clock);
    #1 chk(rdByte_q, 8'h33);
    tx[0] = 8'he1;
    frame(1);
    chk(8'(txPending_q), 8'h00);
    // Resend refused while on air, then held until a flush
    txBusy <= 1'b1;
    tx[0] = 8'he3;
    frame(1);
    chk(8'(resend_q), 8'h00);
    txBusy <= 1'b0;
    frame(1);
    chk(8'(resend_q), 8'h01);
    tx[0] = 8'hb0;
    frame(3);
    chk(8'({txNoAck_q, txLen_q}), 8'h82);
    // Sent and retry events; resend keeps the payload queued
    txSent <= 1'b1;
    retryLimit <= 1'b1;
    @(posedge clock);
    txSent <= 1'b0;
    retryLimit <= 1'b0;
    tx[0] = 8'h07;
    frame(2);
    chk(rx[1], 8'h3f);
    chk(8'(irqLow_q), 8'h00);
    tx[0] = 8'he1;
    frame(1);
    chk(8'({resend_q, txPending_q}), 8'h00);
    // Two acknowledge payloads pend, a third is refused
    tx[0] = 8'hab;
    frame(3);
    tx[0] = 8'ha9;
    frame(2);
    tx[0] = 8'hac;
    frame(4);
    chk(8'({ackReady_q, ackPipe_q, ackLen_q[3:0]}), 8'hb2);
    ackTake <= 1'b1;
    @(posedge clock);
    ackTake <= 1'b0;
    repeat (2) @(posedge clock);
    chk(8'({ackReady_q, ackPipe_q, ackLen_q[3:0]}), 8'h91);
    chk(8'(ackSlot_q), 8'h02);
    // Reset in mid-run drops the forced radio enable
    {tx[0], tx[1]} = 16'hfd00;
    frame(2);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1 chk(8'({radioEnable_q, irqLow_q, link.misoOeN, link.chipSelectLow}),
      8'h07);
    endOfTest();
  end
endmodule
